/* File: design/flame_alt_cfg_map.vh */
`ifndef FLAME_ALT_CFG_MAP_VH
`define FLAME_ALT_CFG_MAP_VH
// register addresses (modbus data address)
`define ADDR_FLAME_OFF_A      16'h9C82
`define ADDR_FLAME_OFF_B      16'h9C83
`define ADDR_FLAME_OFF_C      16'h9C84
`define ADDR_HEAD_SEL_A       16'h9C85
`define ADDR_HEAD_SEL_B       16'h9C86
`define ADDR_HEAD_SEL_C       16'h9C87
`define ADDR_GAIN_A           16'h9C88
`define ADDR_GAIN_B           16'h9C89
`define ADDR_GAIN_C           16'h9C8A
`define ADDR_ALARM_A          16'h9C8B
`define ADDR_ALARM_B          16'h9C8C
`define ADDR_ALARM_C          16'h9C8D
`define ADDR_DELAY_AB         16'h9C8E
`define ADDR_FAIL_RESP_AB     16'h9C8F
`define ADDR_DELAY_C          16'h9C91
`define ADDR_FAIL_RESP_C      16'h9C92
`define ADDR_SWITCH           16'h9C93
`define ADDR_ERROR_CODE       16'h9C94
`define ADDR_SERIAL_RATE      16'h9C95
`define ADDR_SERIAL_PARITY    16'h9C96
`define ADDR_SERIAL_ADDR      16'h9C97
// value limits
`define MAX_COUNTS            16'h0BB7
`define MAX_GAIN              16'h0064
`define FACTORY_RESET_KEY     16'h7570
`define MAX_MULTI_REGS        3'h5
// function codes
`define FUNC_READ             8'h03
`define FUNC_WRITE_ONE        8'h06
`define FUNC_WRITE_MANY       8'h10
// exception codes
`define EXC_NONE              8'h00
`define EXC_ILLEGAL_FUNC      8'h01
`define EXC_ILLEGAL_ADDR      8'h02
`define EXC_ILLEGAL_VALUE     8'h03
// field positions
`define HEAD_LSB              4
`define IR_BIT                6
`define UV_BIT                7
`define SW_CHAN_A_BIT         4
// factory defaults
`define DEF_FLAME_OFF         16'h0000
`define DEF_HEAD_SEL          16'h0000
`define DEF_GAIN              16'h0064
`define DEF_GAIN_OUT          8'h64
`define DEF_ALARM             16'h0000
`define DEF_TIME              16'h0000
`define DEF_SWITCH            16'h0070
`define DEF_RATE              16'h0000
`define DEF_PARITY            16'h0000
`define DEF_SLAVE_ADDR        16'h0001
`endif

/* File: design/flame_alt_cfg_regs.v */
// Contract
// - alternate flame-off threshold per channel, accepted only 0 to 2999
// - config word bits 5:4 select viewing head, zero means none
// - config word bit 6 enables infrared, bit 7 ultraviolet
// - alternate analog output gain per channel, range 0 to 100
// - alternate alarm threshold per channel, range 0 to 2999
// - delay word: low nibble channel A, next nibble channel B
// - fail response word: low nibble channel A, next nibble channel B
// - channel C delay and fail response live in own registers
// - switch bits 4,5,6 pick primary (1) or alternate for A,B,C
// - switch readable from both ports, writable only from RS-422
// - writing 30064 to switch over front port restores factory defaults
// - error code valid on RS-422 reads, front port reads undefined
// - serial rate, parity, address reachable only from front port
// - function 03 reads, function 06 writes one register
// - function 16 writes up to five consecutive registers
// - multi write commits values before first bad one, then exception
`timescale 1ns/100ps
`include "flame_alt_cfg_map.vh"
module flame_alt_cfg_regs (
  // clock and reset
  input  wire        clock,
  input  wire        reset,
  // request from frame decoder (same clock)
  input  wire        req_valid,
  input  wire        req_front_port,
  input  wire [7:0]  req_function,
  input  wire [15:0] req_address,
  input  wire [15:0] req_data,
  input  wire        req_first,
  input  wire        req_last,
  // answer
  output reg         rsp_valid,
  output reg  [15:0] rsp_data,
  output reg  [7:0]  rsp_exception,
  // error code source
  input  wire [15:0] link_error_in,
  // decoded settings
  output reg  [5:0]  viewing_head_index,
  output reg  [2:0]  ir_enable,
  output reg  [2:0]  uv_enable,
  output reg  [2:0]  primary_select,
  output reg  [47:0] flame_off_levels,
  output reg  [47:0] alarm_levels,
  output reg  [23:0] gain_levels,
  output reg  [11:0] delay_secs,
  output reg  [11:0] flame_fail_response_time,
  output reg  [15:0] serial_rate_out,
  output reg  [15:0] serial_parity_out,
  output reg  [15:0] serial_slave_address_out
);

  reg  [15:0] flame_off_reg [0:2];
  reg  [15:0] head_sel_reg  [0:2];
  reg  [15:0] gain_reg      [0:2];
  reg  [15:0] alarm_reg     [0:2];
  reg  [15:0] delay_ab_reg;
  reg  [15:0] fail_ab_reg;
  reg  [15:0] delay_c_reg;
  reg  [15:0] fail_c_reg;
  reg  [15:0] switch_reg;
  reg  [15:0] rate_reg;
  reg  [15:0] parity_reg;
  reg  [15:0] slave_addr_reg;
  reg         abort_reg;
  reg  [2:0]  burst_count_reg;

  reg  [15:0] rd_data;
  reg         addr_ok;
  reg         val_ok;
  reg         wr_allowed;
  reg  [1:0]  chan;
  reg  [3:0]  group;
  wire        is_read;
  wire        is_write;
  wire        func_ok;
  wire        factory_cmd;
  wire [2:0]  burst_now;
  wire        burst_over;

  assign is_read   = (req_function == `FUNC_READ);
  assign is_write  = (req_function == `FUNC_WRITE_ONE) ||
                     (req_function == `FUNC_WRITE_MANY);
  assign func_ok   = is_read || is_write;
  assign factory_cmd = is_write && req_front_port &&
                       (req_address == `ADDR_SWITCH) &&
                       (req_data == `FACTORY_RESET_KEY);
  assign burst_now = req_first ? 3'h1 :
                     (&burst_count_reg) ? burst_count_reg :
                     burst_count_reg + 3'h1;
  assign burst_over = (req_function == `FUNC_WRITE_MANY) &&
                      (burst_now > `MAX_MULTI_REGS);

  // address decode, read mux and value check
  always @* begin
    chan       = 2'h0;
    group      = 4'hF;
    addr_ok    = 1'b1;
    val_ok     = 1'b1;
    wr_allowed = 1'b1;
    rd_data    = 16'h0000;
    // array slots: group picks the kind, chan the channel
    case (req_address)
      `ADDR_FLAME_OFF_A: begin
        group = 4'h0;
        chan  = 2'h0;
      end
      `ADDR_FLAME_OFF_B: begin
        group = 4'h0;
        chan  = 2'h1;
      end
      `ADDR_FLAME_OFF_C: begin
        group = 4'h0;
        chan  = 2'h2;
      end
      `ADDR_HEAD_SEL_A: begin
        group = 4'h1;
        chan  = 2'h0;
      end
      `ADDR_HEAD_SEL_B: begin
        group = 4'h1;
        chan  = 2'h1;
      end
      `ADDR_HEAD_SEL_C: begin
        group = 4'h1;
        chan  = 2'h2;
      end
      `ADDR_GAIN_A: begin
        group = 4'h2;
        chan  = 2'h0;
      end
      `ADDR_GAIN_B: begin
        group = 4'h2;
        chan  = 2'h1;
      end
      `ADDR_GAIN_C: begin
        group = 4'h2;
        chan  = 2'h2;
      end
      `ADDR_ALARM_A: begin
        group = 4'h3;
        chan  = 2'h0;
      end
      `ADDR_ALARM_B: begin
        group = 4'h3;
        chan  = 2'h1;
      end
      `ADDR_ALARM_C: begin
        group = 4'h3;
        chan  = 2'h2;
      end
      default: group = 4'hF;
    endcase
    case (group)
      4'h0: begin
        rd_data = flame_off_reg[chan];
        val_ok  = (req_data <= `MAX_COUNTS);
      end
      4'h1: rd_data = head_sel_reg[chan];
      4'h2: begin
        rd_data = gain_reg[chan];
        val_ok  = (req_data <= `MAX_GAIN);
      end
      4'h3: begin
        rd_data = alarm_reg[chan];
        val_ok  = (req_data <= `MAX_COUNTS);
      end
      default: begin
        case (req_address)
          `ADDR_DELAY_AB:     rd_data = delay_ab_reg;
          `ADDR_FAIL_RESP_AB: rd_data = fail_ab_reg;
          `ADDR_DELAY_C:      rd_data = delay_c_reg;
          `ADDR_FAIL_RESP_C:  rd_data = fail_c_reg;
          `ADDR_SWITCH: begin
            rd_data    = switch_reg;
            wr_allowed = !req_front_port;
          end
          `ADDR_ERROR_CODE: begin
            // front port read undefined, zero here
            rd_data    = req_front_port ? 16'h0000 : link_error_in;
            wr_allowed = 1'b0;
          end
          `ADDR_SERIAL_RATE: begin
            rd_data = rate_reg;
            addr_ok = req_front_port;
          end
          `ADDR_SERIAL_PARITY: begin
            rd_data = parity_reg;
            addr_ok = req_front_port;
          end
          `ADDR_SERIAL_ADDR: begin
            rd_data = slave_addr_reg;
            addr_ok = req_front_port;
          end
          default: addr_ok = 1'b0;
        endcase
      end
    endcase
  end

  integer i;
  always @(posedge clock) begin
    if (reset || (req_valid && factory_cmd)) begin
      for (i = 0; i < 3; i = i + 1) begin
        flame_off_reg[i] <= `DEF_FLAME_OFF;
        head_sel_reg[i]  <= `DEF_HEAD_SEL;
        gain_reg[i]      <= `DEF_GAIN;
        alarm_reg[i]     <= `DEF_ALARM;
      end
      delay_ab_reg   <= `DEF_TIME;
      fail_ab_reg    <= `DEF_TIME;
      delay_c_reg    <= `DEF_TIME;
      fail_c_reg     <= `DEF_TIME;
      switch_reg     <= `DEF_SWITCH;
      rate_reg       <= `DEF_RATE;
      parity_reg     <= `DEF_PARITY;
      slave_addr_reg <= `DEF_SLAVE_ADDR;
    end else if (req_valid && is_write && addr_ok && val_ok && wr_allowed
                 && !(abort_reg && !req_first) && !burst_over) begin
      // only values ahead of the first bad one commit
      case (group)
        4'h0: flame_off_reg[chan] <= req_data;
        4'h1: head_sel_reg[chan]  <= req_data;
        // third gain slot is channel C
        4'h2: gain_reg[chan]      <= req_data;
        4'h3: alarm_reg[chan]     <= req_data;
        default: begin
          case (req_address)
            `ADDR_DELAY_AB:      delay_ab_reg   <= req_data;
            `ADDR_FAIL_RESP_AB:  fail_ab_reg    <= req_data;
            `ADDR_DELAY_C:       delay_c_reg    <= req_data;
            `ADDR_FAIL_RESP_C:   fail_c_reg     <= req_data;
            `ADDR_SWITCH:        switch_reg     <= req_data;
            `ADDR_SERIAL_RATE:   rate_reg       <= req_data;
            `ADDR_SERIAL_PARITY: parity_reg     <= req_data;
            `ADDR_SERIAL_ADDR:   slave_addr_reg <= req_data;
            default: ;
          endcase
        end
      endcase
    end
  end

  // burst tracking and answers
  always @(posedge clock) begin
    if (reset) begin
      abort_reg       <= 1'b0;
      burst_count_reg <= 3'h0;
      rsp_valid       <= 1'b0;
      rsp_data        <= 16'h0000;
      rsp_exception   <= `EXC_NONE;
    end else begin
      rsp_valid <= 1'b0;
      if (req_valid) begin
        burst_count_reg <= req_last ? 3'h0 : burst_now;
        if (req_first)
          rsp_exception <= `EXC_NONE;
        if (!func_ok) begin
          rsp_exception <= `EXC_ILLEGAL_FUNC;
          abort_reg     <= 1'b1;
        end else if (!(abort_reg && !req_first) && !factory_cmd) begin
          if (!addr_ok || (is_write && !wr_allowed) || burst_over) begin
            rsp_exception <= `EXC_ILLEGAL_ADDR;
            abort_reg     <= 1'b1;
          end else if (is_write && !val_ok) begin
            rsp_exception <= `EXC_ILLEGAL_VALUE;
            abort_reg     <= 1'b1;
          end else if (req_first) begin
            abort_reg <= 1'b0;
          end
        end else if (req_first) begin
          abort_reg <= 1'b0;
        end
        rsp_data  <= is_read ? rd_data : req_data;
        rsp_valid <= 1'b1;
      end
    end
  end

  // decoded setting outputs
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : chan_out
      always @(posedge clock) begin
        if (reset) begin
          viewing_head_index[2*g+1:2*g] <= 2'h0;
          ir_enable[g]                  <= 1'b0;
          uv_enable[g]                  <= 1'b0;
          primary_select[g]             <= 1'b1;
          flame_off_levels[16*g+15:16*g] <= `DEF_FLAME_OFF;
          alarm_levels[16*g+15:16*g]     <= `DEF_ALARM;
          gain_levels[8*g+7:8*g]         <= `DEF_GAIN_OUT;
        end else begin
          viewing_head_index[2*g+1:2*g] <=
            head_sel_reg[g][`HEAD_LSB+1:`HEAD_LSB];
          ir_enable[g] <= head_sel_reg[g][`IR_BIT];
          uv_enable[g] <= head_sel_reg[g][`UV_BIT];
          primary_select[g] <= switch_reg[`SW_CHAN_A_BIT+g];
          flame_off_levels[16*g+15:16*g] <= flame_off_reg[g];
          alarm_levels[16*g+15:16*g]     <= alarm_reg[g];
          gain_levels[8*g+7:8*g]         <= gain_reg[g][7:0];
        end
      end
    end
  endgenerate

  always @(posedge clock) begin
    if (reset) begin
      delay_secs               <= 12'h000;
      flame_fail_response_time <= 12'h000;
      serial_rate_out          <= `DEF_RATE;
      serial_parity_out        <= `DEF_PARITY;
      serial_slave_address_out <= `DEF_SLAVE_ADDR;
    end else begin
      delay_secs <= {delay_c_reg[3:0], delay_ab_reg[7:4], delay_ab_reg[3:0]};
      flame_fail_response_time <=
        {fail_c_reg[3:0], fail_ab_reg[7:4], fail_ab_reg[3:0]};
      serial_rate_out          <= rate_reg;
      serial_parity_out        <= parity_reg;
      serial_slave_address_out <= slave_addr_reg;
    end
  end

endmodule // flame_alt_cfg_regs

/* File: test/modbus_master_model.sv */
`timescale 1ns/100ps
module modbus_master_model (
  // clock
  input  wire         clock,
  // request items toward the bank
  output logic        req_valid,
  output logic        req_front_port,
  output logic [7:0]  req_function,
  output logic [15:0] req_address,
  output logic [15:0] req_data,
  output logic        req_first,
  output logic        req_last
);
  initial begin
    req_valid = 1'b0;
    req_front_port = 1'b0;
    req_function = 8'h00;
    req_address = 16'h0000;
    req_data = 16'h0000;
    req_first = 1'b0;
    req_last = 1'b0;
  end
  task item(input f, input [7:0] fn, input [15:0] a, d, input fi, la);
    @(posedge clock);
    req_valid <= 1'b1;
    req_front_port <= f;
    req_function <= fn;
    req_address <= a;
    req_data <= d;
    req_first <= fi;
    req_last <= la;
  endtask
  // released data shows the inverse of the last value
  task idle;
    @(posedge clock);
    req_valid <= 1'b0;
    req_first <= 1'b0;
    req_last <= 1'b0;
    req_data <= ~req_data;
  endtask
endmodule // modbus_master_model

/* File: test/flame_alt_cfg_checker.sv */
`timescale 1ns/100ps
module flame_alt_cfg_checker (
  // clock and reset
  input wire        clock,
  input wire        reset,
  // request and answer
  input wire        req_valid,
  input wire        req_front_port,
  input wire        req_first,
  input wire [7:0]  req_function,
  input wire [15:0] req_address,
  input wire [15:0] req_data,
  input wire        rsp_valid,
  input wire [15:0] rsp_data,
  input wire [7:0]  rsp_exception,
  input wire [23:0] gain_levels
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire go = req_valid && req_first;
  wire w6 = go && req_function == 8'h06;
  sequence s_gain_c_ok;
    w6 && req_address == 16'h9C8A && req_data <= 16'h0064;
  endsequence
  a_answer_next: assert property (req_valid |=> rsp_valid)
    else $error("missing answer");
  a_no_stray: assert property (!req_valid |=> !rsp_valid)
    else $error("stray answer");
  a_write_echo: assert property (w6 |=> rsp_data == $past(req_data))
    else $error("write not echoed");
  a_flame_range: assert property (w6 && req_address == 16'h9C82
    && req_data > 16'h0BB7 |=> rsp_exception == 8'h03) else $error("flame");
  a_gain_range: assert property (w6 && req_address == 16'h9C88
    && req_data > 16'h0064 |=> rsp_exception == 8'h03) else $error("gain");
  a_bad_function: assert property (go && !(req_function inside
    {8'h03, 8'h06, 8'h10}) |=> rsp_exception == 8'h01) else $error("func");
  a_switch_front: assert property (w6 && req_front_port
    && req_address == 16'h9C93 && req_data != 16'h7570
    |=> rsp_exception == 8'h02) else $error("switch");
  a_serial_remote: assert property (w6 && !req_front_port
    && req_address >= 16'h9C95 && req_address <= 16'h9C97
    |=> rsp_exception == 8'h02) else $error("serial");
  a_gain_chan_c: assert property (s_gain_c_ok |-> ##2
    {8'h00, gain_levels[23:16]} == $past(req_data, 2)) else $error("gain c");
endmodule // flame_alt_cfg_checker
bind flame_alt_cfg_regs flame_alt_cfg_checker chk_i (.*);

/* File: test/test_flame_alt_cfg_regs.sv */
`timescale 1ns/100ps
module test_flame_alt_cfg_regs;
  logic        clock;
  logic        reset;
  logic [15:0] link_error_in;
  wire         req_valid, req_front_port, req_first, req_last, rsp_valid;
  wire  [7:0]  req_function, rsp_exception;
  wire  [15:0] req_address, req_data, rsp_data, serial_rate_out;
  wire  [15:0] serial_parity_out, serial_slave_address_out;
  wire  [5:0]  viewing_head_index;
  wire  [2:0]  ir_enable, uv_enable, primary_select;
  wire  [47:0] flame_off_levels, alarm_levels;
  wire  [23:0] gain_levels;
  wire  [11:0] delay_secs, flame_fail_response_time;
  logic [15:0] v [0:5];
  int          mismatches = 0;
  int          compares = 0;
  flame_alt_cfg_regs uut (.*);
  modbus_master_model m (.*);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task chk(input [47:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task op(input f, input [7:0] fn, input [15:0] a, d);
    m.item(f, fn, a, d, 1'b1, 1'b1);
    m.idle;
    #1;
  endtask
  task many(input [15:0] a, input int n);
    for (int i = 0; i < n; i++)
      m.item(1'b0, 8'h10, a + 16'(i), v[i], i == 0, i == n - 1);
    m.idle;
    #1;
  endtask
  task settle;
    @(posedge clock);
    #1;
  endtask
  task t_basic;
    chk(gain_levels, 24'h646464);
    op(0, 8'h06, 16'h9C82, 16'h0BB7);
    chk(rsp_exception, 8'h00);
    op(0, 8'h06, 16'h9C82, 16'h0BB8);
    chk(rsp_exception, 8'h03);
    op(1, 8'h03, 16'h9C82, 16'h0000);
    chk(rsp_data, 16'h0BB7);
    op(0, 8'h06, 16'h9C87, 16'h00F0);
    op(1, 8'h06, 16'h9C85, 16'h0050);
    op(0, 8'h06, 16'h9C8A, 16'h0037);
    op(0, 8'h06, 16'h9C88, 16'h0065);
    chk(rsp_exception, 8'h03);
    settle;
    chk(viewing_head_index, 6'h31);
    chk({ir_enable, uv_enable}, 6'h2C);
    chk(gain_levels, 24'h376464);
    $display("test basic finished");
  endtask
  task t_multi;
    v = '{16'h0005, 16'h0BB7, 16'h0BB8, 16'h000C, 16'h0000, 16'h0000};
    many(16'h9C8B, 4);
    chk(rsp_exception, 8'h03);
    settle;
    chk(alarm_levels, 48'h000000000BB70005);
    chk(delay_secs, 12'h000);
    v = '{6{16'h0010}};
    many(16'h9C82, 6);
    chk(rsp_exception, 8'h02);
    settle;
    chk(viewing_head_index, 6'h35);
    v = '{16'h0021, 16'h0032, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    many(16'h9C8E, 2);
    op(0, 8'h06, 16'h9C91, 16'h0004);
    op(0, 8'h06, 16'h9C92, 16'h0005);
    settle;
    chk(delay_secs, 12'h421);
    chk(flame_fail_response_time, 12'h532);
    $display("test multi finished");
  endtask
  task t_access;
    op(0, 8'h04, 16'h9C82, 16'h0001);
    chk(rsp_exception, 8'h01);
    op(0, 8'h2B, 16'h9C82, 16'h0001);
    chk(rsp_exception, 8'h01);
    op(0, 8'h03, 16'h9C94, 16'h0000);
    chk(rsp_data, 16'h0A5C);
    op(1, 8'h03, 16'h9C94, 16'h0000);
    chk(rsp_data, 16'h0000);
    op(0, 8'h03, 16'h9C90, 16'h0000);
    chk(rsp_exception, 8'h02);
    op(1, 8'h06, 16'h9C97, 16'h0007);
    op(0, 8'h06, 16'h9C95, 16'h0003);
    chk(rsp_exception, 8'h02);
    op(1, 8'h06, 16'h9C96, 16'h0002);
    settle;
    chk(flame_off_levels[15:0], 16'h0010);
    chk(serial_slave_address_out, 16'h0007);
    chk(serial_rate_out, 16'h0000);
    chk(serial_parity_out, 16'h0002);
    $display("test access finished");
  endtask
  task t_switch;
    op(0, 8'h06, 16'h9C93, 16'h0050);
    settle;
    chk(primary_select, 3'h5);
    op(1, 8'h06, 16'h9C93, 16'h0010);
    chk(rsp_exception, 8'h02);
    op(1, 8'h03, 16'h9C93, 16'h0000);
    chk(rsp_data, 16'h0050);
    op(1, 8'h06, 16'h9C93, 16'h7570);
    chk(rsp_exception, 8'h00);
    settle;
    chk({primary_select, gain_levels}, 27'h7646464);
    chk(serial_slave_address_out, 16'h0001);
    chk(serial_parity_out, 16'h0000);
    $display("test switch finished");
  endtask
  task give_verdict;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    mismatches++;
    give_verdict;
  end
  initial begin
    reset = 1'b1;
    link_error_in = 16'h0A5C;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    settle;
    t_basic;
    t_multi;
    t_access;
    t_switch;
    give_verdict;
  end
endmodule // test_flame_alt_cfg_regs
